// >>> hw/psf_sequencer.sv
// sequencer fabric: and-array, sums, macrocells, registers and bus slave
// How it works
// R1: 135 terms: 124 logical, 11 control.
// R2: term takes true, complement or neither.
// R3: both literals of one input give false.
// R4: term with nothing connected gives true.
// R5: output sums use eight to twelve terms.
// R6: buried sums use six to ten terms.
// R7: 23 array inputs, 8 outputs, 9 inputs.
// R8: macrocells have eight modes from three bits.
// R9: macrocell picks registered or combinational sum.
// R10: macrocell picks active high or low.
// R11: macrocell feedback from register or pin.
// R12: feedback offered true and complemented.
// R13: polarity and feedback choice independent.
// R14: output registers: polarity, register feedback.
// R15: disabled pin released, driven value fed back.
// R16: each output enabled by own term, polarity.
// R17: six buried registers, observable on pins.
// R18: shared preset and reset terms, all registers.
// R19: test load forces any register state.
// R20: preset term loads ones next edge.
// R21: reset term clears registers at once.
// R22: observe swaps six pins to buried registers.
// R23: two register groups load separate cycles.
// R24: fuse settings are static configuration inputs.
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module psf_sequencer
    import psf_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // dedicated input pins
    input wire logic [NUM_IN-1:0] dedicatedInputs,
    // bidirectional pins
    input wire logic [NUM_OUT-1:0] bidirectionalPinsIn,
    output logic [NUM_OUT-1:0] bidirectionalPinsOut,
    output logic [NUM_OUT-1:0] bidirectionalPinsOe,
    // static fuse configuration
    input wire logic [NUM_PT*FUSE_W-1:0] productTermFuses,
    input wire logic [3*NUM_OLM-1:0] macrocellMode,
    input wire logic [NUM_OUT-NUM_OLM-1:0] outputPolarityHigh,
    input wire logic [NUM_OUT-1:0] enablePolarityLow,
    // axi4-lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    // pin synchronisers: first stage read only by the second
    logic [NUM_IN-1:0] dedMeta;
    logic [NUM_IN-1:0] dedSync;
    logic [NUM_OUT-1:0] pinMeta;
    logic [NUM_OUT-1:0] pinSync;
    // output registers and buried state registers
    logic [NUM_OUT-1:0] outReg;
    logic [NUM_BSR-1:0] buriedStateRegister;
    // bus side state
    logic awHeld;
    logic wHeld;
    logic [7:0] awaddrHeld;
    logic [31:0] wdataHeld;
    logic [3:0] wstrbHeld;
    logic [NUM_OUT-1:0] loadOutValue;
    logic [NUM_BSR-1:0] loadBsrValue;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dedMeta <= '0;
            dedSync <= '0;
            pinMeta <= '0;
            pinSync <= '0;
        end else begin
            dedMeta <= dedicatedInputs;
            dedSync <= dedMeta;
            pinMeta <= bidirectionalPinsIn;
            pinSync <= pinMeta;
        end
    end

    // array: 9 inputs, 8 output feedbacks, 6 buried feedbacks
    wire logic [ARRAY_W-1:0] arrayIn; // [R7]
    wire logic [NUM_OUT-1:0] feedback;
    wire logic [NUM_PT-1:0] allTerms; // [R1]
    assign arrayIn = {buriedStateRegister, feedback, dedSync};

    // fuses are plain static inputs, never written at run time
    psf_pterm_array #(.TERMS(NUM_PT), .INPUTS(ARRAY_W)) u_array ( // [R24]
        .arrayIn(arrayIn),
        .fuseMap(productTermFuses),
        .terms(allTerms)
    );

    // control terms
    wire logic [NUM_OUT-1:0] enableTerm = allTerms[PT_OE +: NUM_OUT];
    wire logic observeSelectTerm = allTerms[PT_OBS];
    wire logic presetTerm = allTerms[PT_PRESET];
    wire logic resetTerm = allTerms[PT_RESET];

    // sums of the logical terms, each resolved in one cycle
    wire logic [NUM_OUT-1:0] outSum;
    wire logic [NUM_BSR-1:0] bsrSum;
    for (genvar g = 0; g < NUM_OUT; g++) begin : g_outsum
        assign outSum[g] = |allTerms[OUT_PT_BASE[g] +: OUT_PT_CNT[g]]; // [R5]
    end
    for (genvar g = 0; g < NUM_BSR; g++) begin : g_bsrsum
        assign bsrSum[g] = |allTerms[BSR_PT_BASE[g] +: BSR_PT_CNT[g]]; // [R6]
    end

    // bus write decode: both halves held, response slot free
    wire logic writeFire = awHeld && wHeld && !bvalid;
    wire logic hitLoadOut = awaddrHeld == ADDR_LOAD_OUT;
    wire logic hitLoadBsr = awaddrHeld == ADDR_LOAD_BSR;
    wire logic writeMapped = hitLoadOut || hitLoadBsr;
    // one write per cycle, so the two groups always load apart
    wire logic loadOut = writeFire && hitLoadOut && wstrbHeld[0]; // [R23]
    wire logic loadBsr = writeFire && hitLoadBsr && wstrbHeld[0]; // [R23]

    // the reset term clears without the clock; it is a gated async clear
    // so a glitching term can clear registers, as the fabric intends
    wire logic regClear_n = arst_n && !resetTerm;

    // next values: test load over preset over the sums
    wire logic [NUM_OUT-1:0] next_outReg = loadOut ? wdataHeld[NUM_OUT-1:0] // [R19]
        : presetTerm ? '1 : outSum; // [R20]
    wire logic [NUM_BSR-1:0] next_bsr = loadBsr ? wdataHeld[NUM_BSR-1:0] // [R19]
        : presetTerm ? '1 : bsrSum; // [R20]

    // shared preset and reset act on every register
    always_ff @(posedge clock or negedge regClear_n) begin
        if (!regClear_n) begin
            outReg <= '0; // [R18] [R21]
            buriedStateRegister <= '0; // [R17] [R18] [R21]
        end else begin
            outReg <= next_outReg;
            buriedStateRegister <= next_bsr;
        end
    end

    // per-output data, polarity and feedback
    wire logic [NUM_OUT-1:0] outPolHigh;
    wire logic [NUM_OUT-1:0] outData;
    wire logic [NUM_OUT-1:0] normalOe;
    for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
        if (g < NUM_OLM) begin : g_olm
            // three independent mode bits give eight modes
            wire logic [2:0] mode = macrocellMode[3*g +: 3]; // [R8] [R13]
            assign outPolHigh[g] = mode[OLM_POL_HIGH]; // [R10]
            assign outData[g] = mode[OLM_COMB] ? outSum[g] : outReg[g]; // [R9]
            assign feedback[g] = mode[OLM_PIN_FB] ? pinSync[g] : outReg[g]; // [R11]
        end else begin : g_reg
            assign outPolHigh[g] = outputPolarityHigh[g-NUM_OLM]; // [R14]
            assign outData[g] = outReg[g];
            // disabled pin feeds the pin level back, else the register
            assign feedback[g] = normalOe[g] ? outReg[g] : pinSync[g]; // [R14] [R15]
        end
        // enable term with its own polarity
        assign normalOe[g] = enableTerm[g] ^ enablePolarityLow[g]; // [R16]
    end
    // complement of each feedback is formed inside the array
    // active high passes the value, active low inverts it
    wire logic [NUM_OUT-1:0] normalOut = outData ~^ outPolHigh; // [R10] [R12]

    // observe term swaps pins 1..6 to the buried registers
    wire logic [NUM_OUT-1:0] obsMask = observeSelectTerm ?
        ({{NUM_OUT-NUM_BSR{1'b0}}, {NUM_BSR{1'b1}}} << OBS_PIN_BASE) : '0;
    wire logic [NUM_OUT-1:0] obsData =
        {{NUM_OUT-NUM_BSR{1'b0}}, buriedStateRegister} << OBS_PIN_BASE;
    assign bidirectionalPinsOut = (normalOut & ~obsMask) | (obsData & obsMask); // [R22]
    // disabled, unobserved pin is released for outside drive
    assign bidirectionalPinsOe = normalOe | obsMask; // [R15] [R22]

    // write channel: address and data taken in either order
    assign awready = !awHeld;
    assign wready = !wHeld;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            awHeld <= 1'b0;
            awaddrHeld <= '0;
        end else if (awvalid && awready) begin
            awHeld <= 1'b1;
            awaddrHeld <= awaddr;
        end else if (writeFire) begin
            awHeld <= 1'b0;
        end
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wHeld <= 1'b0;
            wdataHeld <= '0;
            wstrbHeld <= '0;
        end else if (wvalid && wready) begin
            wHeld <= 1'b1;
            wdataHeld <= wdata;
            wstrbHeld <= wstrb;
        end else if (writeFire) begin
            wHeld <= 1'b0;
        end
    end

    // write response: unmapped address answers slverr
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (writeFire) begin
            bvalid <= 1'b1;
            bresp <= writeMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // last loaded values kept for read-back
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            loadOutValue <= '0;
            loadBsrValue <= '0;
        end else begin
            if (loadOut) loadOutValue <= wdataHeld[NUM_OUT-1:0];
            if (loadBsr) loadBsrValue <= wdataHeld[NUM_BSR-1:0];
        end
    end

    // read decode
    wire logic readMapped = araddr == ADDR_LOAD_OUT || araddr == ADDR_LOAD_BSR ||
        araddr == ADDR_STATE || araddr == ADDR_PINS;
    wire logic [31:0] readWord =
        araddr == ADDR_LOAD_OUT ? {24'h0, loadOutValue} :
        araddr == ADDR_LOAD_BSR ? {26'h0, loadBsrValue} :
        araddr == ADDR_STATE ? {18'h0, buriedStateRegister, outReg} :
        araddr == ADDR_PINS ? {16'h0, bidirectionalPinsOe, bidirectionalPinsOut} :
        32'h0;
    assign arready = !rvalid;

    // read data held until rready
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= readWord;
            rresp <= readMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // checks
    presetLoad_a: assert property (@(posedge clock) disable iff (!arst_n) // [R20]
        presetTerm && !loadOut && !loadBsr |=> resetTerm || (&outReg && &buriedStateRegister))
        else $error("preset did not load ones");
    resetClear_a: assert property (@(posedge clock) disable iff (!arst_n) // [R21]
        resetTerm |-> outReg == '0 && buriedStateRegister == '0)
        else $error("reset term left a register set");
    observePins_a: assert property (@(posedge clock) disable iff (!arst_n) // [R22]
        observeSelectTerm |-> bidirectionalPinsOut[OBS_PIN_BASE +: NUM_BSR] == buriedStateRegister
        && &bidirectionalPinsOe[OBS_PIN_BASE +: NUM_BSR])
        else $error("observe did not show buried registers");
    enablePol_a: assert property (@(posedge clock) disable iff (!arst_n) // [R16]
        bidirectionalPinsOe[NUM_OUT-1] == (enableTerm[NUM_OUT-1] ^ enablePolarityLow[NUM_OUT-1]))
        else $error("enable polarity wrong");
    testLoad_a: assert property (@(posedge clock) disable iff (!arst_n) // [R19]
        loadOut && !resetTerm ##1 !resetTerm |-> outReg == $past(wdataHeld[NUM_OUT-1:0]))
        else $error("test load lost");
    combMode_a: assert property (@(posedge clock) disable iff (!arst_n) // [R9]
        macrocellMode[OLM_COMB] && !observeSelectTerm |->
        bidirectionalPinsOut[0] == (outSum[0] ~^ macrocellMode[OLM_POL_HIGH]))
        else $error("combinational macrocell output wrong");
    pinFeedback_a: assert property (@(posedge clock) disable iff (!arst_n) // [R11]
        macrocellMode[OLM_PIN_FB] |-> arrayIn[AI_FB] == pinSync[0])
        else $error("pin feedback not selected");
    falseTerm_a: assert property (@(posedge clock) disable iff (!arst_n) // [R3]
        productTermFuses[0] && productTermFuses[1] |-> !allTerms[0])
        else $error("contradictory term not false");
    outFollow_a: assert property (@(posedge clock) disable iff (!arst_n) // [R5]
        !presetTerm && !loadOut ##1 !resetTerm |-> outReg[4] == $past(outSum[4]))
        else $error("output register missed its sum");
    bsrFollow_a: assert property (@(posedge clock) disable iff (!arst_n) // [R6]
        !presetTerm && !loadBsr ##1 !resetTerm |-> buriedStateRegister == $past(bsrSum))
        else $error("buried register missed its sum");
endmodule : psf_sequencer
`default_nettype wire

// >>> hw/psf_pkg.sv
// shared constants of the sum-of-products sequencer fabric
package psf_pkg;
    // array shape
    localparam int NUM_IN = 9;
    localparam int NUM_OUT = 8;
    localparam int NUM_OLM = 4;
    localparam int NUM_BSR = 6;
    localparam int ARRAY_W = 23;
    localparam int FUSE_W = 2 * ARRAY_W;
    localparam int NUM_LOGIC_PT = 124;
    localparam int NUM_CTRL_PT = 11;
    localparam int NUM_PT = 135;
    // array input positions
    localparam int AI_DED = 0;
    localparam int AI_FB = 9;
    localparam int AI_BSR = 17;
    // control term positions
    localparam int PT_OE = 124;
    localparam int PT_OBS = 132;
    localparam int PT_PRESET = 133;
    localparam int PT_RESET = 134;
    // terms per output sum and per buried sum
    localparam int OUT_PT_CNT [NUM_OUT] = '{8, 9, 10, 11, 12, 11, 10, 9};
    localparam int OUT_PT_BASE [NUM_OUT] = '{0, 8, 17, 27, 38, 50, 61, 71};
    localparam int BSR_PT_CNT [NUM_BSR] = '{6, 10, 8, 7, 7, 6};
    localparam int BSR_PT_BASE [NUM_BSR] = '{80, 86, 96, 104, 111, 118};
    // macrocell mode bits
    localparam int OLM_POL_HIGH = 0;
    localparam int OLM_COMB = 1;
    localparam int OLM_PIN_FB = 2;
    // buried registers show on pins 1..6
    localparam int OBS_PIN_BASE = 1;
    // register map
    localparam logic [7:0] ADDR_LOAD_OUT = 8'h00;
    localparam logic [7:0] ADDR_LOAD_BSR = 8'h04;
    localparam logic [7:0] ADDR_STATE = 8'h08;
    localparam logic [7:0] ADDR_PINS = 8'h0c;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : psf_pkg

// >>> hw/psf_pterm_array.sv
// programmable and-array: one product term per fuse row
`timescale 1ns/10ps
`default_nettype none
module psf_pterm_array
    import psf_pkg::*;
#(
    parameter int TERMS = NUM_PT,
    parameter int INPUTS = ARRAY_W
) (
    // array inputs
    input wire logic [INPUTS-1:0] arrayIn,
    // fuse rows: bit 2i true, bit 2i+1 complement, 1 = intact
    input wire logic [TERMS*2*INPUTS-1:0] fuseMap,
    // term results
    output logic [TERMS-1:0] terms
);
    // refuse shapes the map cannot hold
    if (TERMS < 1 || INPUTS < 1) begin : g_check
        $error("psf_pterm_array: bad shape");
    end

    // every input offered in true and complemented form
    wire logic [2*INPUTS-1:0] bothForms;
    for (genvar i = 0; i < INPUTS; i++) begin : g_forms
        assign bothForms[2*i] = arrayIn[i];
        assign bothForms[2*i+1] = ~arrayIn[i];
    end

    // an intact fuse demands its literal; a blown one is a don't-care
    for (genvar t = 0; t < TERMS; t++) begin : g_term
        wire logic [2*INPUTS-1:0] row = fuseMap[t*2*INPUTS +: 2*INPUTS];
        // both forms intact gives false, all blown gives true
        assign terms[t] = &(bothForms | ~row); // [R2] [R3] [R4]
    end
endmodule : psf_pterm_array
`default_nettype wire

// >>> test/psf_pin_partner.sv
// pin-side model: resolves each bidirectional pin from device, external driver and pull-up
`timescale 1ns/10ps
`default_nettype none
module psf_pin_partner
    import psf_pkg::*;
(
    // device side
    input wire logic [NUM_OUT-1:0] pinOut,
    input wire logic [NUM_OUT-1:0] pinOe,
    // external drivers
    input wire logic [NUM_OUT-1:0] extVal,
    input wire logic [NUM_OUT-1:0] extEn,
    // resolved level
    output logic [NUM_OUT-1:0] pinLevel
);
    // an enabled device pin wins over the outside driver, so no fight is ever modelled
    always_comb begin
        for (int k = 0; k < NUM_OUT; k++) begin
            if (pinOe[k]) begin
                pinLevel[k] = pinOut[k];
            end else if (extEn[k]) begin
                pinLevel[k] = extVal[k];
            end else begin
                pinLevel[k] = 1'b1; // pull-up holds an undriven pin
            end
        end
    end
endmodule : psf_pin_partner
`default_nettype wire

// >>> test/psf_sequencer_tb.sv
// self-checking bench for the sequencer fabric
`timescale 1ns/10ps
`default_nettype none
module psf_sequencer_tb
    import psf_pkg::*;
();
    localparam logic [31:0] ALL = 32'hffffffff;
    localparam int DED_PT = OUT_PT_BASE[4] + OUT_PT_CNT[4] - 1; // last term of pin 4 sum
    // clock, reset, pins
    logic clock = 1'b0;
    logic arst_n;
    logic [NUM_IN-1:0] dedicatedInputs;
    logic [NUM_OUT-1:0] pinsIn, pinsOut, pinsOe, extVal, extEn;
    // fuse configuration
    logic [NUM_PT*FUSE_W-1:0] fuses;
    logic [3*NUM_OLM-1:0] mode;
    logic [NUM_OUT-NUM_OLM-1:0] polHigh;
    logic [NUM_OUT-1:0] enLow;
    // bus
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, data;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    int numErrors = 0;
    int checkCount = 0;

    always #5 clock = ~clock;

    psf_sequencer i_dut (.clock(clock), .arst_n(arst_n), .dedicatedInputs(dedicatedInputs),
        .bidirectionalPinsIn(pinsIn), .bidirectionalPinsOut(pinsOut), .bidirectionalPinsOe(pinsOe),
        .productTermFuses(fuses), .macrocellMode(mode), .outputPolarityHigh(polHigh),
        .enablePolarityLow(enLow), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

    psf_pin_partner i_pins (.pinOut(pinsOut), .pinOe(pinsOe), .extVal(extVal), .extEn(extEn),
        .pinLevel(pinsIn));

    // verdict and stop
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checkCount, numErrors);
        if (numErrors == 0 && checkCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // masked data compare
    task automatic check_data(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        checkCount++;
        if ((got & m) !== (exp & m)) begin
            numErrors++;
            $display("mismatch at %0t: got %h expected %h", $time, got & m, exp & m);
        end
    endtask : check_data

    // response code compare
    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        checkCount++;
        if (got !== exp) begin
            numErrors++;
            $display("mismatch at %0t: resp %h expected %h", $time, got, exp);
        end
    endtask : check_resp

    // readies are sampled at the falling edge: inputs only move after rising edges
    task automatic bus_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        logic takeA, takeW, takeB;
        takeB = 1'b0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!takeB) begin
            @(negedge clock);
            takeA = awvalid && awready;
            takeW = wvalid && wready;
            takeB = (bvalid === 1'b1);
            r = bresp;
            @(posedge clock);
            if (takeA) awvalid <= 1'b0;
            if (takeW) wvalid <= 1'b0;
            if (takeB) bready <= 1'b0;
        end
    endtask : bus_write

    // single read, held until the answer
    task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic takeA, takeR;
        takeR = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!takeR) begin
            @(negedge clock);
            takeA = arvalid && arready;
            takeR = (rvalid === 1'b1);
            d = rdata;
            r = rresp;
            @(posedge clock);
            if (takeA) arvalid <= 1'b0;
            if (takeR) rready <= 1'b0;
        end
    endtask : bus_read

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] v);
        bus_write(a, v, resp);
        check_resp(resp, RESP_OKAY);
    endtask : wr_ok

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        bus_read(a, data, resp);
        check_resp(resp, RESP_OKAY);
        check_data(data, exp, m);
    endtask : rd_chk

    // every register holds itself through one feedback term; ctl: observe, preset, reset terms
    task automatic restart(input logic [11:0] m, input logic [7:0] el, input logic [2:0] ctl);
        logic [NUM_PT*FUSE_W-1:0] f;
        f = '1;
        for (int k = 0; k < NUM_OUT; k++) begin
            f[OUT_PT_BASE[k]*FUSE_W +: FUSE_W] = '0;
            f[OUT_PT_BASE[k]*FUSE_W + 2*(AI_FB+k)] = 1'b1;
            f[(PT_OE+k)*FUSE_W +: FUSE_W] = '0;
        end
        for (int j = 0; j < NUM_BSR; j++) begin
            f[BSR_PT_BASE[j]*FUSE_W +: FUSE_W] = '0;
            f[BSR_PT_BASE[j]*FUSE_W + 2*(AI_BSR+j)] = 1'b1;
        end
        // input 0 true and input 1 complemented
        f[DED_PT*FUSE_W +: FUSE_W] = '0;
        f[DED_PT*FUSE_W + 0] = 1'b1;
        f[DED_PT*FUSE_W + 3] = 1'b1;
        for (int c = 0; c < 3; c++) begin
            if (ctl[c]) f[(PT_OBS+c)*FUSE_W +: FUSE_W] = '0;
        end
        arst_n <= 1'b0;
        fuses <= f;
        mode <= m;
        polHigh <= m[0] ? 4'hf : 4'h0;
        enLow <= el;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
    endtask : restart

    // watchdog: the whole list needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        numErrors++;
        end_of_test();
    end

    initial begin
        dedicatedInputs <= '0;
        extVal <= 8'h06;
        extEn <= 8'h0f;
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b0;
        arvalid <= 1'b0;
        rready <= 1'b0;
        awaddr <= '0;
        araddr <= '0;
        wdata <= '0;
        wstrb <= 4'hf;
        restart(12'h249, 8'h00, 3'b000);
        rd_chk(ADDR_STATE, 32'h0, ALL);
        wr_ok(ADDR_LOAD_OUT, 32'ha5);
        wr_ok(ADDR_LOAD_BSR, 32'h2a);
        rd_chk(ADDR_STATE, 32'h2aa5, ALL);
        rd_chk(ADDR_LOAD_OUT, 32'ha5, 32'hff);
        rd_chk(ADDR_PINS, 32'hffa5, ALL);
        dedicatedInputs <= 9'h001;
        repeat (4) @(posedge clock); // two sync stages, the register edge, then one spare edge
        rd_chk(ADDR_STATE, 32'h2ab5, ALL);
        dedicatedInputs <= '0;
        // unmapped place: refused, nothing changes
        bus_write(8'h10, 32'hff, resp);
        check_resp(resp, RESP_SLVERR);
        bus_read(8'h10, data, resp);
        check_resp(resp, RESP_SLVERR);
        rd_chk(ADDR_STATE, 32'h2ab5, ALL);
        // active low, pin feedback on macrocells, their pins released
        restart(12'h924, 8'h0f, 3'b000);
        wr_ok(ADDR_LOAD_OUT, 32'ha5);
        repeat (4) @(posedge clock);
        rd_chk(ADDR_STATE, 32'ha6, 32'hff);
        rd_chk(ADDR_PINS, 32'hf050, 32'hfff0);
        // preset term, then preset with reset term
        restart(12'h249, 8'h00, 3'b010);
        rd_chk(ADDR_STATE, 32'h3fff, ALL);
        restart(12'h249, 8'h00, 3'b110);
        wr_ok(ADDR_LOAD_OUT, 32'hff);
        rd_chk(ADDR_STATE, 32'h0, ALL);
        // observe term with every output disabled
        restart(12'h249, 8'hff, 3'b001);
        wr_ok(ADDR_LOAD_BSR, 32'h2a);
        rd_chk(ADDR_PINS, 32'h7e54, 32'hff7e);
        end_of_test();
    end
endmodule : psf_sequencer_tb
`default_nettype wire
